// ---- hdl/gpp_pkg.sv ----
// Functional notes
// - eight pins usable as gpio, crossbar resource or analog; six-pin variant
// - pin seven is shared with the debug data line
// - port latch read always returns present pin state regardless of crossbar
// - after reset cells are hi-z with pull-ups on until crossbar enabled
// - input mode bit 0 selects analog, 1 selects digital
// - analog pin disables pull-up, output driver and input receiver
// - analog pin always reads back as 0
// - push-pull pin drives pad high for 1 and low for 0
// - open-drain pin drives low for 0 and floats for 1
// - hi-z digital pin has pull-up on; pull-up off while driving low
// - global pull-up disable bit turns off all weak pull-ups
// - digital pin reads actual pad level, not the output value
// - converter/comparator on any pin; reference pin zero, oscillator pin three
// - crossbar places resources only on pins whose skip bit is 0
// - serial transmit and receive always sit on pins four and five
// - two event captures on any digital pin, never on analog pins
// - resources go in priority order to lowest free unskipped pin
// - output drivers stay off while crossbar is disabled
// - two-wire bus pins always operate open-drain
package gpp_pkg;
    localparam int NUM_PINS     = 8;
    localparam int NUM_PINS_MIN = 6;
    localparam int NUM_RES      = 11;
    localparam int PIN_DEBUG    = 7;
    localparam int PIN_VREF     = 0;
    localparam int PIN_EXTOSC   = 3;
    localparam int PIN_UART_TX  = 4;
    localparam int PIN_UART_RX  = 5;
    localparam int SEL_W        = 3;
    localparam logic [7:0] LATCH_RST = 8'hFF;
    localparam logic [7:0] MDIN_RST  = 8'hFF;
    localparam logic [7:0] ZERO8     = 8'h00;
    // resource indices in crossbar priority order
    localparam int RES_SDA  = 0;
    localparam int RES_SCL  = 1;
    localparam int RES_CP   = 2;
    localparam int RES_CPA  = 3;
    localparam int RES_SYS  = 4;
    localparam int RES_CEX0 = 5;
    localparam int RES_CEX1 = 6;
    localparam int RES_CEX2 = 7;
    localparam int RES_ECI  = 8;
    localparam int RES_T0   = 9;
    localparam int RES_T1   = 10;
    typedef enum logic [1:0] {GPP_EDGE_NONE, GPP_EDGE_RISE, GPP_EDGE_FALL}
        gpp_edge_e;
endpackage

// ---- hdl/gpp_edge_cap.sv ----
`timescale 1ns/1ps
`default_nettype none
// event capture on one selectable digital pin
module gpp_edge_cap (
    input  wire logic                      ref_clk,    // clock
    input  wire logic                      rst_n,      // sync reset
    input  wire logic                      clk_en,     // freeze when low
    input  wire logic [gpp_pkg::NUM_PINS-1:0] pin_dig, // gated pin levels
    input  wire logic [gpp_pkg::NUM_PINS-1:0] pin_is_dig, // digital mode
    input  wire logic [gpp_pkg::SEL_W-1:0] sel,        // pin select
    input  wire logic                      invert,     // 1: falling edge
    output logic                           event_p     // one-cycle event
);
    logic       lvl_q;
    logic       lvl_d;
    logic       ok;
    assign lvl_d = pin_dig[sel] ^ invert;
    assign ok    = pin_is_dig[sel];
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            // track the pin in reset so no false edge follows release
            lvl_q   <= lvl_d;
            event_p <= 1'b0;
        end else if (clk_en) begin
            lvl_q   <= lvl_d;
            event_p <= ok & lvl_d & ~lvl_q;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/gpp_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpp_port #(
    parameter int PINS = gpp_pkg::NUM_PINS
) (
    input  wire logic                  ref_clk,            // 200 MHz clock
    input  wire logic                  rst_n,              // sync reset
    input  wire logic                  clk_en,             // freeze when low
    input  wire logic                  latch_wr,           // latch write strobe
    input  wire logic [7:0]            latch_wdata,        // latch data
    input  wire logic [7:0]            pin_input_mode_bits,  // 1 digital
    input  wire logic [7:0]            pin_output_mode_bits, // 1 push-pull
    input  wire logic [7:0]            crossbar_skip_bits, // 1 skipped
    input  wire logic [7:0]            peripheral_route_select_a, // enables
    input  wire logic [7:0]            peripheral_route_select_b, // enables
    input  wire logic                  crossbar_enable,    // crossbar on
    input  wire logic                  weak_pullup_disable,// pull-ups off
    input  wire logic [7:0]            ext_int_pin_select, // event pins/pol
    input  wire logic [7:0]            pad_in,             // pad levels
    output logic [7:0]                 pad_out,            // pad drive value
    output logic [7:0]                 pad_oe_n,           // low = driving
    output logic [7:0]                 pad_pullup,         // weak pull-up on
    output logic [7:0]                 port_zero_latch,    // latch read
    output logic [7:0]                 pin_read,           // port read value
    output logic [7:0]                 analog_sel,         // analog enabled
    output logic                       debug_data_in,      // debug data pin
    input  wire logic                  uart_tx,            // serial tx
    output logic                       uart_rx,            // serial rx
    input  wire logic                  sda_out,            // bus data out
    output logic                       sda_in,             // bus data in
    input  wire logic                  scl_out,            // bus clock out
    output logic                       scl_in,             // bus clock in
    input  wire logic                  cmp_sync,           // comparator out
    input  wire logic                  cmp_async,          // async comparator
    input  wire logic                  system_clock_output_out,         // clock out
    input  wire logic [2:0]            cex_out,            // counter channels
    output logic [2:0]                 cex_in,             // channel inputs
    output logic                       eci_in,             // counter ext clock
    output logic                       t0_in,              // timer 0 input
    output logic                       t1_in,              // timer 1 input
    output logic                       ext_osc_pin,        // oscillator pin
    output logic                       vref_pin_analog,    // reference pin ok
    output logic                       event0,             // event 0 pulse
    output logic                       event1              // event 1 pulse
);
    localparam int N = gpp_pkg::NUM_PINS;
    localparam int R = gpp_pkg::NUM_RES;

    // ****************************************************
    // port latch and read-back
    // ****************************************************
    logic [N-1:0] latch_q;
    logic [N-1:0] latch_d;
    logic [N-1:0] pin_mask;
    logic [N-1:0] is_dig;
    logic [N-1:0] pin_lvl;

    assign latch_d = latch_wr ? latch_wdata : latch_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            latch_q <= gpp_pkg::LATCH_RST;
        end else if (clk_en) begin
            latch_q <= latch_d;
        end
    end

    // six-pin variant keeps unbonded pins idle, neither digital nor analog
    genvar gm;
    generate
        for (gm = 0; gm < N; gm++) begin : g_mask
            assign pin_mask[gm] = (gm < PINS);
        end
    endgenerate

    assign is_dig   = pin_input_mode_bits & pin_mask;
    assign pin_lvl  = pad_in & is_dig;
    assign analog_sel = ~pin_input_mode_bits & pin_mask;
    assign vref_pin_analog = analog_sel[gpp_pkg::PIN_VREF];
    assign ext_osc_pin     = pad_in[gpp_pkg::PIN_EXTOSC];
    assign debug_data_in   = pad_in[gpp_pkg::PIN_DEBUG];

    // read path registered, so the latch read shows pads, not latch
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_read        <= gpp_pkg::ZERO8;
            port_zero_latch <= gpp_pkg::ZERO8;
        end else if (clk_en) begin
            pin_read        <= pin_lvl;
            port_zero_latch <= pin_lvl;
        end
    end

    // ****************************************************
    // priority crossbar
    // ****************************************************
    logic [R-1:0]   res_en;
    logic [R-1:0]   res_od;
    logic [N-1:0]   taken   [0:R];
    logic [N-1:0]   onehot  [0:R-1];
    logic [R-1:0]   res_out;
    logic [N-1:0]   xb_claim;
    logic [N-1:0]   xb_od;
    logic [N-1:0]   xb_val;

    assign res_en[gpp_pkg::RES_SDA]  = peripheral_route_select_a[2];
    assign res_en[gpp_pkg::RES_SCL]  = peripheral_route_select_a[2];
    assign res_en[gpp_pkg::RES_CP]   = peripheral_route_select_a[4];
    assign res_en[gpp_pkg::RES_CPA]  = peripheral_route_select_a[5];
    assign res_en[gpp_pkg::RES_SYS]  = peripheral_route_select_a[3];
    assign res_en[gpp_pkg::RES_CEX0] = |peripheral_route_select_a[7:6];
    assign res_en[gpp_pkg::RES_CEX1] = peripheral_route_select_a[7];
    assign res_en[gpp_pkg::RES_CEX2] = &peripheral_route_select_a[7:6];
    assign res_en[gpp_pkg::RES_ECI]  = peripheral_route_select_b[0];
    assign res_en[gpp_pkg::RES_T0]   = peripheral_route_select_b[1];
    assign res_en[gpp_pkg::RES_T1]   = peripheral_route_select_b[2];

    assign res_od  = {{(R-2){1'b0}}, 2'b11};
    assign res_out = {1'b0, 1'b0, 1'b0, cex_out, system_clock_output_out, cmp_async,
                      cmp_sync, scl_out, sda_out};

    // pins four and five are always held by the serial port
    assign taken[0] = crossbar_skip_bits | ~pin_mask |
        (N'(1) << gpp_pkg::PIN_UART_TX) |
        (N'(1) << gpp_pkg::PIN_UART_RX);

    genvar gr;
    generate
        for (gr = 0; gr < R; gr++) begin : g_res
            logic [N-1:0] free;
            assign free = ~taken[gr];
            // lowest free pin via two's complement isolate
            assign onehot[gr] = res_en[gr] ? (free & (~free + N'(1)))
                                           : {N{1'b0}};
            assign taken[gr+1] = taken[gr] | onehot[gr];
        end
    endgenerate

    always_comb begin
        xb_claim = {N{1'b0}};
        xb_od    = {N{1'b0}};
        xb_val   = {N{1'b0}};
        for (int r = 0; r < R; r++) begin
            xb_claim = xb_claim | onehot[r];
            if (res_od[r]) begin
                xb_od = xb_od | onehot[r];
            end
            if (res_out[r]) begin
                xb_val = xb_val | onehot[r];
            end
        end
    end

    // input-only resources and timers never drive a pad high
    logic [N-1:0] in_only;
    assign in_only = onehot[gpp_pkg::RES_ECI] | onehot[gpp_pkg::RES_T0] |
                     onehot[gpp_pkg::RES_T1];

    function automatic logic pick(input logic [N-1:0] oh,
                                  input logic [N-1:0] lv);
        pick = |(oh & lv);
    endfunction

    assign sda_in  = crossbar_enable ? pick(onehot[gpp_pkg::RES_SDA],
                                            pin_lvl) : 1'b1;
    assign scl_in  = crossbar_enable ? pick(onehot[gpp_pkg::RES_SCL],
                                            pin_lvl) : 1'b1;
    assign eci_in  = pick(onehot[gpp_pkg::RES_ECI], pin_lvl);
    assign t0_in   = pick(onehot[gpp_pkg::RES_T0], pin_lvl);
    assign t1_in   = pick(onehot[gpp_pkg::RES_T1], pin_lvl);
    assign uart_rx = crossbar_enable ? pin_lvl[gpp_pkg::PIN_UART_RX]
                                     : 1'b1;
    genvar gc;
    generate
        for (gc = 0; gc < 3; gc++) begin : g_cex
            assign cex_in[gc] = pick(onehot[gpp_pkg::RES_CEX0 + gc],
                                     pin_lvl);
        end
    endgenerate

    // ****************************************************
    // pad cell control
    // ****************************************************
    logic [N-1:0] val;
    logic [N-1:0] drv_low;
    logic [N-1:0] drv_high;
    logic [N-1:0] od_mode;
    logic [N-1:0] tx_mask;
    logic [N-1:0] out_q;
    logic [N-1:0] oe_n_q;
    logic [N-1:0] pu_q;

    assign tx_mask = N'(1) << gpp_pkg::PIN_UART_TX;
    // gpio pins take the latch; crossbar pins take their resource
    assign val = (xb_claim & ~in_only & xb_val) |
                 (tx_mask & {N{uart_tx}}) |
                 (~xb_claim & ~tx_mask & latch_q);
    // an input-only resource pin takes value 0, so a digital one drives low
    assign od_mode  = ~pin_output_mode_bits | xb_od;
    assign drv_low  = {N{crossbar_enable}} & is_dig & ~val;
    assign drv_high = {N{crossbar_enable}} & is_dig & val &
                      ~od_mode & ~(xb_claim & in_only);

    // hi-z digital pin pulled up unless disabled or driving low
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            out_q  <= gpp_pkg::ZERO8;
            oe_n_q <= gpp_pkg::LATCH_RST;
            pu_q   <= gpp_pkg::MDIN_RST;
        end else if (clk_en) begin
            out_q  <= drv_high;
            oe_n_q <= ~(drv_low | drv_high);
            pu_q   <= is_dig & ~drv_low & ~drv_high &
                      {N{~weak_pullup_disable}};
        end
    end
    assign pad_out    = out_q;
    assign pad_oe_n   = oe_n_q;
    assign pad_pullup = pu_q;

    // ****************************************************
    // external event capture
    // ****************************************************
    gpp_edge_cap u_ev0 (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .pin_dig    (pin_lvl),
        .pin_is_dig (is_dig),
        .sel        (ext_int_pin_select[2:0]),
        .invert     (ext_int_pin_select[3]),
        .event_p    (event0)
    );
    gpp_edge_cap u_ev1 (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .pin_dig    (pin_lvl),
        .pin_is_dig (is_dig),
        .sel        (ext_int_pin_select[6:4]),
        .invert     (ext_int_pin_select[7]),
        .event_p    (event1)
    );
endmodule
`default_nettype wire

// ---- verification/gpp_pads.sv ----
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// external circuits at the pads
// ************************************************************
module gpp_pads (
    input  wire logic       ref_clk,    // clock
    input  wire logic [7:0] pad_out,    // device drive value
    input  wire logic [7:0] pad_oe_n,   // low = device drives
    input  wire logic [7:0] pad_pullup, // weak pull-up on
    input  wire logic [7:0] ext_en,     // external driver on
    input  wire logic [7:0] ext_val,    // external drive value
    output logic      [7:0] pad_in      // resolved pad level
);
    logic [7:0] last_q;

    // a floating pad flips so a stale level never looks valid
    always_ff @(posedge ref_clk) begin
        last_q <= pad_in;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pad_oe_n[i]) begin
                pad_in[i] = pad_out[i];
            end else if (ext_en[i]) begin
                pad_in[i] = ext_val[i];
            end else if (pad_pullup[i]) begin
                pad_in[i] = 1'b1;
            end else begin
                pad_in[i] = ~last_q[i];
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/gpp_port_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// port cell checker
// ************************************************************
module gpp_port_chk (
    input wire logic       ref_clk,              // clock
    input wire logic       rst_n,                // sync reset
    input wire logic       clk_en,               // freeze when low
    input wire logic       latch_wr,             // latch write strobe
    input wire logic [7:0] latch_wdata,          // latch data
    input wire logic [7:0] pin_input_mode_bits,  // 1 digital
    input wire logic [7:0] pin_output_mode_bits, // 1 push-pull
    input wire logic [7:0] crossbar_skip_bits,   // 1 skipped
    input wire logic       crossbar_enable,      // crossbar on
    input wire logic       weak_pullup_disable,  // pull-ups off
    input wire logic [7:0] ext_int_pin_select,   // event pins
    input wire logic [7:0] pad_in,               // pad levels
    input wire logic [7:0] pad_out,              // drive value
    input wire logic [7:0] pad_oe_n,             // low = driving
    input wire logic [7:0] pad_pullup,           // pull-up on
    input wire logic [7:0] port_zero_latch,      // latch read
    input wire logic [7:0] pin_read,             // port read
    input wire logic       event0                // event pulse
);
    // serial pins left out: their drive belongs to the serial port
    localparam logic [7:0] GPIO_M = 8'hCF;
    logic       ok_q;
    logic [7:0] latch_q;
    logic [7:0] dig;
    logic [2:0] sel;

    assign dig = pin_input_mode_bits;
    assign sel = ext_int_pin_select[2:0];
    always_ff @(posedge ref_clk) begin
        ok_q <= rst_n & clk_en;
        if (!rst_n) begin
            latch_q <= 8'hFF;
        end else if (clk_en && latch_wr) begin
            latch_q <= latch_wdata;
        end
    end

    default clocking cb_main @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_drivers_off: assert property (
        ok_q && !$past(crossbar_enable) |-> pad_oe_n == 8'hFF)
        else $error("pad driven while crossbar off");
    a_analog_quiet: assert property (
        ok_q |-> ((~pad_oe_n | pad_pullup | pin_read) & ~$past(dig)) == 8'h00)
        else $error("analog pin drives, pulls or reads nonzero");
    a_pull_global: assert property (
        ok_q && $past(weak_pullup_disable) |-> pad_pullup == 8'h00)
        else $error("pull-up on while globally disabled");
    a_pull_idle: assert property (
        ok_q && !$past(weak_pullup_disable)
        |-> (pad_oe_n & ~pad_pullup & $past(dig)) == 8'h00)
        else $error("idle digital pin without pull-up");
    a_pull_low_off: assert property (
        (~pad_oe_n & ~pad_out & pad_pullup) == 8'h00)
        else $error("pull-up on while driving low");
    a_push_pull: assert property (
        ok_q && !$past(latch_wr) && $past(crossbar_enable)
        |-> ((pad_oe_n | (pad_out ^ latch_q)) & GPIO_M & $past(dig
        & pin_output_mode_bits & crossbar_skip_bits)) == 8'h00)
        else $error("push-pull pin not following latch");
    a_open_drain: assert property (
        ok_q && !$past(latch_wr) && $past(crossbar_enable)
        |-> (((pad_oe_n ^ latch_q) | (~pad_oe_n & pad_out)) & GPIO_M
        & $past(dig & ~pin_output_mode_bits & crossbar_skip_bits)) == 8'h00)
        else $error("open-drain pin wrong drive");
    a_read_pad: assert property (
        ok_q |-> pin_read == ($past(pad_in) & $past(dig))
        && port_zero_latch == pin_read)
        else $error("read-back differs from pad level");
    a_event_rise: assert property (
        clk_en && $rose(pad_in[sel]) && dig[sel] && !ext_int_pin_select[3]
        && $stable(ext_int_pin_select) |-> ##[1:3] event0)
        else $error("rising edge gave no event");
    a_event_pulse: assert property (
        event0 |=> !event0)
        else $error("event longer than one cycle");
endmodule
bind gpp_port gpp_port_chk i_chk (
    .ref_clk, .rst_n, .clk_en, .latch_wr, .latch_wdata,
    .pin_input_mode_bits, .pin_output_mode_bits, .crossbar_skip_bits,
    .crossbar_enable, .weak_pullup_disable, .ext_int_pin_select, .pad_in,
    .pad_out, .pad_oe_n, .pad_pullup, .port_zero_latch, .pin_read, .event0
);
`default_nettype wire

// ---- verification/tb_gpp_port.sv ----
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// port cell bench
// ************************************************************
module tb_gpp_port;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic latch_wr = 1'b0;
    logic cb = 1'b0;
    logic wpud = 1'b0;
    logic [7:0] latch_wdata = 8'h00;
    logic [7:0] mdin = 8'hFF;
    logic [7:0] mdout = 8'h00;
    logic [7:0] skip = 8'hFF;
    logic [7:0] eisel = 8'h00;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] route_a = 8'h00;
    logic utx = 1'b1;
    logic sda_o = 1'b1;
    logic scl_o = 1'b1;
    logic [7:0] pad_in, pad_out, pad_oe_n, pad_pullup;
    logic [7:0] port_zero_latch, pin_read, analog_sel;
    logic dbg, uart_rx, osc, event0;
    int mismatches = 0;
    int total_checks = 0;

    always #2.5 ref_clk = ~ref_clk;

    gpp_port i_dut (
        .ref_clk, .rst_n, .clk_en, .latch_wr, .latch_wdata,
        .pin_input_mode_bits(mdin), .pin_output_mode_bits(mdout),
        .crossbar_skip_bits(skip), .peripheral_route_select_a(route_a),
        .peripheral_route_select_b(8'h00), .crossbar_enable(cb),
        .weak_pullup_disable(wpud), .ext_int_pin_select(eisel), .pad_in,
        .pad_out, .pad_oe_n, .pad_pullup, .port_zero_latch, .pin_read,
        .analog_sel, .debug_data_in(dbg), .uart_tx(utx), .uart_rx,
        .sda_out(sda_o), .sda_in(), .scl_out(scl_o), .scl_in(),
        .cmp_sync(1'b0), .cmp_async(1'b0), .system_clock_output_out(1'b0),
        .cex_out(3'h0), .cex_in(), .eci_in(), .t0_in(), .t1_in(),
        .ext_osc_pin(osc), .vref_pin_analog(), .event0, .event1()
    );
    gpp_pads i_pads (
        .ref_clk, .pad_out, .pad_oe_n, .pad_pullup, .ext_en, .ext_val,
        .pad_in
    );

    task automatic chk(input string n, input logic [7:0] s,
                       input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // three cycles: one to the pad, one back through the read register, one to spare
    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] v);
        @(posedge ref_clk);
        latch_wr <= 1'b1;
        latch_wdata <= v;
        @(posedge ref_clk);
        latch_wr <= 1'b0;
    endtask
    task automatic gpio_case(input logic [7:0] v, eoe, eout, epu, erd);
        wr(v);
        settle();
        chk("oe_n", pad_oe_n & 8'hCF, eoe);
        chk("out", pad_out & 8'h8F, eout);
        chk("pullup", pad_pullup & 8'hCF, epu);
        chk("read", pin_read & 8'hCF, erd);
    endtask
    task automatic ev_case(input logic [7:0] sel, md, v0, v1, e);
        logic [7:0] seen;
        seen = 8'h00;
        @(posedge ref_clk);
        eisel <= sel;
        mdin <= md;
        ext_val <= v0;
        settle();
        @(posedge ref_clk);
        ext_val <= v1;
        repeat (5) begin
            @(posedge ref_clk);
            #1;
            seen = seen + 8'(event0);
        end
        chk("events", seen, e);
    endtask
    task automatic t_reset_off();
        settle();
        chk("oe_n", pad_oe_n, 8'hFF);
        chk("pullup", pad_pullup, 8'hFF);
        chk("read", pin_read, 8'hFF);
        @(posedge ref_clk);
        mdout <= 8'hFF;
        wr(8'h00);
        settle();
        chk("oe_n off", pad_oe_n, 8'hFF);
    endtask
    task automatic t_gpio();
        @(posedge ref_clk);
        mdout <= 8'h0F;
        skip <= 8'hFF;
        cb <= 1'b1;
        gpio_case(8'h5A, 8'h40, 8'h0A, 8'h40, 8'h4A);
        gpio_case(8'hA5, 8'h80, 8'h05, 8'h80, 8'h85);
        wpud <= 1'b1;
        settle();
        chk("pull off", pad_pullup, 8'h00);
        wpud <= 1'b0;
    endtask
    task automatic t_analog();
        @(posedge ref_clk);
        mdin <= 8'hF0;
        ext_en <= 8'h0F;
        ext_val <= 8'h0F;
        skip <= 8'hFF;
        settle();
        chk("an read", pin_read & 8'h0F, 8'h00);
        chk("an oe_n", pad_oe_n & 8'h0F, 8'h0F);
        chk("an pull", pad_pullup & 8'h0F, 8'h00);
        chk("an sel", analog_sel, 8'h0F);
        mdin <= 8'hFF;
    endtask
    // two-wire bus on the two lowest unskipped pins, serial on pin four
    task automatic t_route();
        @(posedge ref_clk);
        ext_en <= 8'h00;
        mdout <= 8'hFF;
        skip <= 8'hFC;
        route_a <= 8'h04;
        sda_o <= 1'b0;
        utx <= 1'b0;
        settle();
        chk("xb oe_n", pad_oe_n & 8'h13, 8'h02);
        chk("xb out", pad_out & 8'h13, 8'h00);
        @(posedge ref_clk);
        utx <= 1'b1;
        settle();
        chk("tx out", pad_out & 8'h13, 8'h10);
        @(posedge ref_clk);
        route_a <= 8'h00;
        skip <= 8'hFF;
        sda_o <= 1'b1;
    endtask
    task automatic t_pads();
        logic [7:0] pat [2];
        pat = '{8'hC3, 8'h3C};
        @(posedge ref_clk);
        mdout <= 8'h00;
        wr(8'hFF);
        ext_en <= 8'hFF;
        foreach (pat[i]) begin
            ext_val <= pat[i];
            settle();
            chk("pad read", pin_read, pat[i]);
            chk("latch read", port_zero_latch, pat[i]);
            chk("aux", {5'h00, dbg, osc, uart_rx},
                {5'h00, pat[i][7], pat[i][3], pat[i][5]});
            @(posedge ref_clk);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset_off();
        t_gpio();
        t_analog();
        t_route();
        t_pads();
        ev_case(8'h02, 8'hFF, 8'h00, 8'h04, 8'h01);
        ev_case(8'h0A, 8'hFF, 8'h04, 8'h00, 8'h01);
        ev_case(8'h02, 8'hFB, 8'h00, 8'h04, 8'h00);
        complete_run();
    end
    initial begin
        #20000;
        mismatches++;
        complete_run();
    end
endmodule
`default_nettype wire
